// ### src/smci_buf.sv
`timescale 1ns/100ps
module smci_buf #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = smci_pkg::BUF_DEPTH
) (
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
        begin : g_chk
            $error("buffer depth must be a power of two, at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem_r   [DEPTH];
    logic [WIDTH-1:0] mem_nxt [DEPTH];
    logic [PW-1:0]    wp_r;
    logic [PW-1:0]    wp_nxt;
    logic [PW-1:0]    rp_r;
    logic [PW-1:0]    rp_nxt;
    logic [CW-1:0]    cnt_r;
    logic [CW-1:0]    cnt_nxt;
    logic             wr;
    logic             rd;

    assign in_ready  = (cnt_r != CW'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];

    always_comb
    begin
        wr      = in_valid && in_ready;
        rd      = out_valid && out_ready;
        mem_nxt = mem_r;
        if (wr)
        begin
            mem_nxt[wp_r] = in_data;
        end
        wp_nxt  = wp_r + PW'(wr);
        rp_nxt  = rp_r + PW'(rd);
        cnt_nxt = cnt_r + CW'(wr) - CW'(rd);
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end
        else
        begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
        mem_r <= mem_nxt;
    end

endmodule // smci_buf

// ### src/smci_pkg.sv
package smci_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // serial framing and timing
    localparam int unsigned CLK_HZ     = 250_000_000;
    localparam int unsigned BAUD_RATE  = 2400;
    localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_RATE;
    localparam int unsigned DATA_BITS  = 8;
    localparam int unsigned STOP_BITS  = 2;
    localparam int unsigned FRAME_BITS = 1 + DATA_BITS + STOP_BITS;
    localparam int unsigned RX_STOP_IX = DATA_BITS + 1;

    ////////////////////////////////////////////////////////////////////////////
    // reply layout: reading, space, wavelength, cr, lf
    localparam int unsigned READ_CHARS = 6;
    localparam int unsigned WL_CHARS   = 4;
    localparam int unsigned RESP_CHARS = READ_CHARS + 1 + WL_CHARS + 2;
    localparam int unsigned BUF_DEPTH  = 2;
    localparam logic [31:0] WL1_TEXT_DEF = 32'h2020_2031;
    localparam logic [31:0] WL2_TEXT_DEF = 32'h2020_2032;

    ////////////////////////////////////////////////////////////////////////////
    // character codes
    localparam logic [7:0] CH_G  = 8'h47;
    localparam logic [7:0] CH_Y  = 8'h59;
    localparam logic [7:0] CH_X  = 8'h58;
    localparam logic [7:0] CH_B  = 8'h42;
    localparam logic [7:0] CH_A  = 8'h41;
    localparam logic [7:0] CH_R  = 8'h52;
    localparam logic [7:0] CH_S  = 8'h53;
    localparam logic [7:0] CH_C  = 8'h43;
    localparam logic [7:0] CH_D  = 8'h44;
    localparam logic [7:0] CH_0  = 8'h30;
    localparam logic [7:0] CH_3  = 8'h33;
    localparam logic [7:0] CH_5  = 8'h35;
    localparam logic [7:0] CH_SP = 8'h20;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_LF = 8'h0a;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {MODE_BR, MODE_ABS, MODE_REL} smci_mode_t;

    typedef struct packed {
        smci_mode_t mode;
        logic       wl_second;
    } smci_ctrl_t;

    typedef struct packed {
        logic store_baseline;
        logic clear_baseline;
        logic store_dark;
        logic zero_rel;
    } smci_evt_t;

    typedef struct packed {
        logic [8*READ_CHARS-1:0] text;
        logic                    wl_second;
    } smci_meas_t;

    localparam smci_ctrl_t CTRL_RST = '{mode: MODE_BR, wl_second: 1'b0};

endpackage

// ### src/smci_top.sv
`timescale 1ns/100ps
module smci_top #(
    parameter int unsigned BIT_CYCLES = smci_pkg::BIT_CYCLES,
    parameter logic [31:0] WL1_TEXT   = smci_pkg::WL1_TEXT_DEF,
    parameter logic [31:0] WL2_TEXT   = smci_pkg::WL2_TEXT_DEF
) (
    input  wire logic                                  clk_sys,
    input  wire logic                                  nrst,
    input  wire logic                                  rxd,
    output logic                                       txd,
    output logic                                       rts,
    output logic                                       dtr,
    input  wire logic                                  cts,
    input  wire logic                                  dcd,
    input  wire logic                                  meas_valid,
    input  wire logic [8*smci_pkg::READ_CHARS-1:0]     meas_text,
    output smci_pkg::smci_ctrl_t                       ctrl,
    output smci_pkg::smci_evt_t                        evt
);
    localparam int unsigned DW = $clog2(BIT_CYCLES + 1);

    generate
        if (BIT_CYCLES < 16)
        begin : g_chk
            $error("bit period too short for mid-bit sampling");
        end
    endgenerate

    typedef enum logic [1:0] {S_IDLE, S_ACK, S_READ} smci_fsm_t;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers, first stage read only by the second
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic       rxd_s;
    logic       cts_s;
    logic       dcd_s;

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            sync1_r <= 3'h7;
            sync2_r <= 3'h7;
        end
        else
        begin
            sync1_r <= {dcd, cts, rxd};
            sync2_r <= sync1_r;
        end
    end

    assign rxd_s = sync2_r[0];
    assign cts_s = sync2_r[1];
    assign dcd_s = sync2_r[2];

    ////////////////////////////////////////////////////////////////////////////
    // handshake outputs come up once reset is released
    logic hs_r;

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            hs_r <= 1'b0;
        else
            hs_r <= 1'b1;
    end

    assign rts = hs_r;
    assign dtr = hs_r;

    ////////////////////////////////////////////////////////////////////////////
    // receiver: mid-bit sampling, waits only for the first stop bit
    logic          rx_busy_r, rx_busy_nxt;
    logic [DW-1:0] rx_div_r, rx_div_nxt;
    logic [3:0]    rx_ix_r, rx_ix_nxt;
    logic [7:0]    rx_sh_r, rx_sh_nxt;
    logic          rx_done_r, rx_done_nxt;

    always_comb
    begin
        rx_busy_nxt = rx_busy_r;
        rx_div_nxt  = rx_div_r;
        rx_ix_nxt   = rx_ix_r;
        rx_sh_nxt   = rx_sh_r;
        rx_done_nxt = 1'b0;
        if (!rx_busy_r)
        begin
            if (!rxd_s)
            begin
                rx_busy_nxt = 1'b1;
                rx_div_nxt  = DW'(BIT_CYCLES / 2);
                rx_ix_nxt   = '0;
            end
        end
        else if (rx_div_r != '0)
        begin
            rx_div_nxt = rx_div_r - 1'b1;
        end
        else
        begin
            rx_div_nxt = DW'(BIT_CYCLES - 1);
            rx_ix_nxt  = rx_ix_r + 1'b1;
            if (rx_ix_r == '0 && rxd_s)
            begin
                rx_busy_nxt = 1'b0;                         // glitch, not a start bit
            end
            else if (rx_ix_r == 4'(smci_pkg::RX_STOP_IX))
            begin
                rx_busy_nxt = 1'b0;
                // framing error or carrier low: the byte is dropped unanswered
                rx_done_nxt = rxd_s && dcd_s;
            end
            else if (rx_ix_r != '0)
            begin
                rx_sh_nxt = {rxd_s, rx_sh_r[7:1]};
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            rx_busy_r <= 1'b0;
            rx_div_r  <= '0;
            rx_ix_r   <= '0;
            rx_sh_r   <= '0;
            rx_done_r <= 1'b0;
        end
        else
        begin
            rx_busy_r <= rx_busy_nxt;
            rx_div_r  <= rx_div_nxt;
            rx_ix_r   <= rx_ix_nxt;
            rx_sh_r   <= rx_sh_nxt;
            rx_done_r <= rx_done_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reply character for position ix of a reading
    function automatic logic [7:0] resp_char(input logic [3:0] ix, input smci_pkg::smci_meas_t m);
        int          i;
        logic [31:0] wl;
        i  = int'(ix);
        wl = m.wl_second ? WL2_TEXT : WL1_TEXT;
        if (i < smci_pkg::READ_CHARS)
            resp_char = m.text[8*(smci_pkg::READ_CHARS-1-i) +: 8];
        else if (i == smci_pkg::READ_CHARS)
            resp_char = smci_pkg::CH_SP;
        else if (i < smci_pkg::READ_CHARS + 1 + smci_pkg::WL_CHARS)
            resp_char = wl[8*(smci_pkg::READ_CHARS+smci_pkg::WL_CHARS-i) +: 8];
        else if (i == smci_pkg::RESP_CHARS - 2)
            resp_char = smci_pkg::CH_CR;
        else
            resp_char = smci_pkg::CH_LF;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // command interpreter
    smci_fsm_t            fsm_r, fsm_nxt;
    logic                 pend_r, pend_nxt;
    logic [7:0]           pend_byte_r, pend_byte_nxt;
    logic [7:0]           ack_r, ack_nxt;
    logic [3:0]           idx_r, idx_nxt;
    smci_pkg::smci_ctrl_t ctrl_r, ctrl_nxt;
    smci_pkg::smci_evt_t  evt_r, evt_nxt;
    smci_pkg::smci_meas_t meas_r, meas_nxt;
    smci_pkg::smci_meas_t snap_r, snap_nxt;
    logic                 bi_valid;
    logic                 bi_ready;
    logic [7:0]           bi_data;

    always_comb
    begin
        fsm_nxt       = fsm_r;
        pend_nxt      = pend_r;
        pend_byte_nxt = pend_byte_r;
        ack_nxt       = ack_r;
        idx_nxt       = idx_r;
        ctrl_nxt      = ctrl_r;
        evt_nxt       = '0;
        meas_nxt      = meas_r;
        snap_nxt      = snap_r;
        bi_valid      = 1'b0;
        bi_data       = ack_r;
        if (meas_valid)
        begin
            meas_nxt = '{text: meas_text, wl_second: ctrl_r.wl_second};
        end
        unique case (fsm_r)
            S_IDLE:
            begin
                if (pend_r)
                begin
                    pend_nxt = 1'b0;
                    fsm_nxt  = S_ACK;
                    ack_nxt  = smci_pkg::CH_Y;
                    unique case (pend_byte_r)
                        smci_pkg::CH_B: ctrl_nxt.mode = smci_pkg::MODE_BR;
                        smci_pkg::CH_A: ctrl_nxt.mode = smci_pkg::MODE_ABS;
                        smci_pkg::CH_R: ctrl_nxt.mode = smci_pkg::MODE_REL;
                        smci_pkg::CH_S, smci_pkg::CH_C:
                        begin
                            if (ctrl_r.mode == smci_pkg::MODE_BR)
                            begin
                                evt_nxt.store_baseline = (pend_byte_r == smci_pkg::CH_S);
                                evt_nxt.clear_baseline = (pend_byte_r == smci_pkg::CH_C);
                            end
                            else
                                ack_nxt = smci_pkg::CH_X;
                        end
                        smci_pkg::CH_D:
                        begin
                            if (ctrl_r.mode != smci_pkg::MODE_BR)
                                evt_nxt.store_dark = 1'b1;
                            else
                                ack_nxt = smci_pkg::CH_X;
                        end
                        smci_pkg::CH_0:
                        begin
                            if (ctrl_r.mode == smci_pkg::MODE_REL)
                                evt_nxt.zero_rel = 1'b1;
                            else
                                ack_nxt = smci_pkg::CH_X;
                        end
                        smci_pkg::CH_3: ctrl_nxt.wl_second = 1'b0;
                        smci_pkg::CH_5: ctrl_nxt.wl_second = 1'b1;
                        smci_pkg::CH_G:
                        begin
                            fsm_nxt  = S_READ;
                            idx_nxt  = '0;
                            snap_nxt = meas_r;
                        end
                        default: ack_nxt = smci_pkg::CH_X;
                    endcase
                end
            end
            S_ACK:
            begin
                // settings were registered a cycle earlier, so the ack follows them
                bi_valid = 1'b1;
                if (bi_ready)
                    fsm_nxt = S_IDLE;
            end
            S_READ:
            begin
                bi_valid = 1'b1;
                bi_data  = resp_char(idx_r, snap_r);
                if (bi_ready)
                begin
                    idx_nxt = idx_r + 1'b1;
                    if (idx_r == 4'(smci_pkg::RESP_CHARS - 1))
                        fsm_nxt = S_IDLE;
                end
            end
        endcase
        // a byte landing as the previous one is taken is kept: set wins
        if (rx_done_r)
        begin
            pend_nxt      = 1'b1;
            pend_byte_nxt = rx_sh_r;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            fsm_r       <= S_IDLE;
            pend_r      <= 1'b0;
            pend_byte_r <= '0;
            ack_r       <= '0;
            idx_r       <= '0;
            ctrl_r      <= smci_pkg::CTRL_RST;
            evt_r       <= '0;
            meas_r      <= '0;
            snap_r      <= '0;
        end
        else
        begin
            fsm_r       <= fsm_nxt;
            pend_r      <= pend_nxt;
            pend_byte_r <= pend_byte_nxt;
            ack_r       <= ack_nxt;
            idx_r       <= idx_nxt;
            ctrl_r      <= ctrl_nxt;
            evt_r       <= evt_nxt;
            meas_r      <= meas_nxt;
            snap_r      <= snap_nxt;
        end
    end

    assign ctrl = ctrl_r;
    assign evt  = evt_r;

    ////////////////////////////////////////////////////////////////////////////
    // reply buffer and transmitter
    logic                              bo_valid;
    logic                              bo_ready;
    logic [7:0]                        bo_data;
    logic                              tx_busy_r, tx_busy_nxt;
    logic [DW-1:0]                     tx_div_r, tx_div_nxt;
    logic [3:0]                        tx_bits_r, tx_bits_nxt;
    logic [smci_pkg::FRAME_BITS-1:0]   tx_sh_r, tx_sh_nxt;

    smci_buf #(
        .WIDTH (8),
        .DEPTH (smci_pkg::BUF_DEPTH)
    ) u_buf (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .in_valid  (bi_valid),
        .in_ready  (bi_ready),
        .in_data   (bi_data),
        .out_valid (bo_valid),
        .out_ready (bo_ready),
        .out_data  (bo_data)
    );

    // a character already started finishes even if clear-to-send drops
    assign bo_ready = !tx_busy_r && cts_s;

    always_comb
    begin
        tx_busy_nxt = tx_busy_r;
        tx_div_nxt  = tx_div_r;
        tx_bits_nxt = tx_bits_r;
        tx_sh_nxt   = tx_sh_r;
        if (!tx_busy_r)
        begin
            if (bo_valid && bo_ready)
            begin
                tx_busy_nxt = 1'b1;
                tx_div_nxt  = DW'(BIT_CYCLES - 1);
                tx_bits_nxt = 4'(smci_pkg::FRAME_BITS);
                tx_sh_nxt   = {{smci_pkg::STOP_BITS{1'b1}}, bo_data, 1'b0};
            end
        end
        else if (tx_div_r != '0)
        begin
            tx_div_nxt = tx_div_r - 1'b1;
        end
        else
        begin
            tx_div_nxt  = DW'(BIT_CYCLES - 1);
            tx_sh_nxt   = {1'b1, tx_sh_r[smci_pkg::FRAME_BITS-1:1]};
            tx_bits_nxt = tx_bits_r - 1'b1;
            tx_busy_nxt = (tx_bits_r != 4'h1);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            tx_busy_r <= 1'b0;
            tx_div_r  <= '0;
            tx_bits_r <= '0;
            tx_sh_r   <= '1;
        end
        else
        begin
            tx_busy_r <= tx_busy_nxt;
            tx_div_r  <= tx_div_nxt;
            tx_bits_r <= tx_bits_nxt;
            tx_sh_r   <= tx_sh_nxt;
        end
    end

    assign txd = tx_sh_r[0];

    ////////////////////////////////////////////////////////////////////////////
    // checks
    logic cmd_go;
    assign cmd_go = (fsm_r == S_IDLE) && pend_r;

    a_hs_raised: assert property (@(posedge clk_sys) disable iff (!nrst)
        $past(nrst) |-> rts && dtr) else $error("rts or dtr low after reset");
    a_cts_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
        !cts_s && !tx_busy_r |=> !tx_busy_r) else $error("character started without clear-to-send");
    a_start_bit: assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(tx_busy_r) |-> !txd ##1 !txd) else $error("start bit missing");
    a_one_reply: assert property (@(posedge clk_sys) disable iff (!nrst)
        cmd_go && pend_byte_r != smci_pkg::CH_G |=> fsm_r == S_ACK && bi_valid ##1 fsm_r != S_READ)
        else $error("command not answered once");
    a_mode_ack: assert property (@(posedge clk_sys) disable iff (!nrst)
        cmd_go && pend_byte_r == smci_pkg::CH_R |=> ctrl_r.mode == smci_pkg::MODE_REL && ack_r == smci_pkg::CH_Y)
        else $error("relative mode not taken");
    a_refuse_keep: assert property (@(posedge clk_sys) disable iff (!nrst)
        cmd_go && pend_byte_r == smci_pkg::CH_S && ctrl_r.mode != smci_pkg::MODE_BR
        |=> ack_r == smci_pkg::CH_X && $stable(ctrl_r) && !evt_r.store_baseline)
        else $error("baseline store accepted outside backreflection");
    a_dark_mode: assert property (@(posedge clk_sys) disable iff (!nrst)
        cmd_go && pend_byte_r == smci_pkg::CH_D |=> evt_r.store_dark == (ack_r == smci_pkg::CH_Y))
        else $error("dark offset pulse and ack disagree");
    a_zero_rel: assert property (@(posedge clk_sys) disable iff (!nrst)
        cmd_go && pend_byte_r == smci_pkg::CH_0 && ctrl_r.mode == smci_pkg::MODE_REL
        |=> evt_r.zero_rel && ack_r == smci_pkg::CH_Y) else $error("zero reference refused");
    a_wl_second: assert property (@(posedge clk_sys) disable iff (!nrst)
        cmd_go && pend_byte_r == smci_pkg::CH_5 |=> ctrl_r.wl_second) else $error("second source not selected");
    a_read_start: assert property (@(posedge clk_sys) disable iff (!nrst)
        cmd_go && pend_byte_r == smci_pkg::CH_G |=> fsm_r == S_READ && idx_r == 4'h0)
        else $error("reading not started");

endmodule // smci_top

// ### testbench/smci_host.sv
`timescale 1ns/100ps
module smci_host #(
    parameter int unsigned BIT_CYCLES = 32
) (
    input  wire logic clk_sys,
    input  wire logic txd,
    output logic      rxd
);
    logic [7:0] rx_q[$];
    int         frame_errs = 0;

    initial rxd = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // one lone character per command, lsb first, two stop bits, no terminator
    task automatic send_char(input logic [7:0] c);
        logic [10:0] f;
        f = {2'b11, c, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            @(negedge clk_sys) rxd = f[i];
            repeat (BIT_CYCLES - 1) @(negedge clk_sys);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // sample mid-bit; a short or long bit time shows up as a framing error
    always
    begin : rx_side
        logic [7:0] c;
        @(negedge txd);
        repeat (BIT_CYCLES / 2) @(posedge clk_sys);
        if (txd !== 1'b0)
            frame_errs++;
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT_CYCLES) @(posedge clk_sys);
            c[i] = txd;
        end
        repeat (2)
        begin
            repeat (BIT_CYCLES) @(posedge clk_sys);
            if (txd !== 1'b1)
                frame_errs++;
        end
        rx_q.push_back(c);
    end
endmodule // smci_host

// ### testbench/smci_top_tb.sv
`timescale 1ns/100ps
module smci_top_tb;
    logic                 clk_sys;
    logic                 nrst;
    logic                 rxd;
    logic                 txd;
    logic                 rts;
    logic                 dtr;
    logic                 cts;
    logic                 dcd;
    logic                 meas_valid;
    logic [47:0]          meas_text;
    smci_pkg::smci_ctrl_t ctrl;
    smci_pkg::smci_evt_t  evt;
    smci_pkg::smci_ctrl_t ctrl_at_tx;
    logic [3:0]           evt_acc;
    logic                 evt_clr;
    int                   failures = 0;
    int                   total_checks = 0;

    always #2 clk_sys = ~clk_sys;
    // evt pulses last one cycle, so gather them per command
    always @(posedge clk_sys) evt_acc <= evt_clr ? 4'h0 : (evt_acc | evt);
    always @(negedge txd) ctrl_at_tx = ctrl;

    smci_top #(.BIT_CYCLES(32)) u_smci_top (.clk_sys(clk_sys), .nrst(nrst), .rxd(rxd), .txd(txd),
        .rts(rts), .dtr(dtr), .cts(cts), .dcd(dcd), .meas_valid(meas_valid), .meas_text(meas_text),
        .ctrl(ctrl), .evt(evt));
    smci_host #(.BIT_CYCLES(32)) u_smci_host (.clk_sys(clk_sys), .txd(txd), .rxd(rxd));

    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // bounded wait for one reply character
    task automatic get_char(output logic [7:0] c);
        int n;
        n = 0;
        while (u_smci_host.rx_q.size() == 0 && n < 2000)
        begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 2000)
        begin
            failures++;
            $display("[FAIL] %0t reply timeout", $time);
            final_report();
        end
        else
            c = u_smci_host.rx_q.pop_front();
    endtask

    task automatic cmd(input logic [7:0] c, input logic [7:0] rep, input logic [2:0] ct, input logic [3:0] ev);
        logic [7:0] got;
        @(negedge clk_sys) evt_clr = 1'b1;
        @(negedge clk_sys) evt_clr = 1'b0;
        u_smci_host.send_char(c);
        get_char(got);
        chk(got, rep, "reply");
        chk(ctrl_at_tx, ct, "setting at ack");
        chk(ctrl, ct, "setting");
        chk(evt_acc, ev, "events");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        repeat (16) @(negedge clk_sys);
        chk({txd, rts, dtr}, 3'h4, "pins in reset");
        nrst = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk({txd, rts, dtr}, 3'h7, "pins after reset");
        chk(ctrl, 3'h0, "ctrl after reset");
        $display("t_reset done");
    endtask

    // ctrl value is {mode, wl_second}; evt is {store_bl, clear_bl, dark, zero}
    task automatic t_cmds();
        cmd(smci_pkg::CH_S, smci_pkg::CH_Y, 3'h0, 4'h8);
        cmd(smci_pkg::CH_C, smci_pkg::CH_Y, 3'h0, 4'h4);
        cmd(smci_pkg::CH_D, smci_pkg::CH_X, 3'h0, 4'h0);
        cmd(smci_pkg::CH_0, smci_pkg::CH_X, 3'h0, 4'h0);
        cmd(smci_pkg::CH_A, smci_pkg::CH_Y, 3'h2, 4'h0);
        cmd(smci_pkg::CH_S, smci_pkg::CH_X, 3'h2, 4'h0);
        cmd(smci_pkg::CH_C, smci_pkg::CH_X, 3'h2, 4'h0);
        cmd(smci_pkg::CH_D, smci_pkg::CH_Y, 3'h2, 4'h2);
        cmd(smci_pkg::CH_0, smci_pkg::CH_X, 3'h2, 4'h0);
        cmd(smci_pkg::CH_R, smci_pkg::CH_Y, 3'h4, 4'h0);
        cmd(smci_pkg::CH_D, smci_pkg::CH_Y, 3'h4, 4'h2);
        cmd(smci_pkg::CH_0, smci_pkg::CH_Y, 3'h4, 4'h1);
        cmd(smci_pkg::CH_5, smci_pkg::CH_Y, 3'h5, 4'h0);
        cmd(smci_pkg::CH_3, smci_pkg::CH_Y, 3'h4, 4'h0);
        cmd(smci_pkg::CH_5, smci_pkg::CH_Y, 3'h5, 4'h0);
        cmd(8'h51, smci_pkg::CH_X, 3'h5, 4'h0);
        cmd(smci_pkg::CH_B, smci_pkg::CH_Y, 3'h1, 4'h0);
        $display("t_cmds done");
    endtask

    task automatic t_read();
        logic [103:0] exp;
        logic [7:0]   got;
        exp = {48'h2d34_352e_3320, smci_pkg::CH_SP, smci_pkg::WL2_TEXT_DEF, smci_pkg::CH_CR, smci_pkg::CH_LF};
        @(negedge clk_sys);
        meas_text = exp[103:56];
        meas_valid = 1'b1;
        @(negedge clk_sys) meas_valid = 1'b0;
        u_smci_host.send_char(smci_pkg::CH_G);
        for (int i = 0; i < 13; i++)
        begin
            get_char(got);
            chk(got, exp[103 - 8 * i -: 8], "reading char");
        end
        repeat (800) @(posedge clk_sys);
        chk(u_smci_host.rx_q.size(), 0, "extra reply chars");
        $display("t_read done");
    endtask

    // a held-off reply must wait, not be lost, once clear-to-send returns
    task automatic t_cts();
        logic [7:0] got;
        @(negedge clk_sys) cts = 1'b0;
        u_smci_host.send_char(smci_pkg::CH_A);
        repeat (1500) @(posedge clk_sys);
        chk(u_smci_host.rx_q.size(), 0, "sent while cts low");
        @(negedge clk_sys) cts = 1'b1;
        get_char(got);
        chk(got, smci_pkg::CH_Y, "held reply");
        $display("t_cts done");
    endtask

    task automatic t_dcd();
        @(negedge clk_sys) dcd = 1'b0;
        u_smci_host.send_char(smci_pkg::CH_R);
        repeat (1500) @(posedge clk_sys);
        chk(u_smci_host.rx_q.size(), 0, "reply without carrier");
        chk(ctrl, 3'h3, "ctrl without carrier");
        @(negedge clk_sys) dcd = 1'b1;
        cmd(smci_pkg::CH_R, smci_pkg::CH_Y, 3'h5, 4'h0);
        $display("t_dcd done");
    endtask

    initial
    begin
        clk_sys = 1'b0;
        nrst = 1'b0;
        cts = 1'b1;
        dcd = 1'b1;
        meas_valid = 1'b0;
        meas_text = 48'h0000_0000_0000;
        evt_clr = 1'b1;
        t_reset();
        t_cmds();
        t_read();
        t_cts();
        t_dcd();
        chk(u_smci_host.frame_errs, 0, "framing errors");
        final_report();
    end
endmodule // smci_top_tb
